// ---- src/aperture_dram_defs.svh ----
// Offsets, field positions, reset values and sizes of the two hub registers
`ifndef APERTURE_DRAM_DEFS_SVH
`define APERTURE_DRAM_DEFS_SVH

// Configuration functions
`define FN_HOST 3'h0
`define FN_GPORT 3'h1
`define FN_GFX 3'h2

// Register offsets inside the host-bridge function
`define OFS_APERTURE_CONTROL 8'h51
`define OFS_DRAM_ROW_POPULATION 8'h52

// Aperture control fields
`define APC_SELECT_BIT 0
`define APC_ENABLE_BIT 1
`define APC_LOCK_BIT 2
`define APC_RESERVED_HI 7
`define APC_RESERVED_LO 3

// Row population fields
`define POP_DIMM1_HI 7
`define POP_DIMM1_LO 4
`define POP_DIMM0_HI 3
`define POP_DIMM0_LO 0

// Reset values and read answers
`define APC_RESET 8'h00
`define POP_RESET 8'h00
`define CODE_EMPTY 4'h0
`define READ_HIDDEN 8'hff
`define READ_ZEROED 8'h00

// Memory array size
`define DRAM_ROWS 6
`define DIMM_SLOTS 3
`define DIMMS_HERE 2
`define ROW_WIDTH_BITS 64

`endif

// ---- src/aperture_dram_pkg.sv ----
// Types shared by the aperture control and row population logic
package aperture_dram_pkg;

  typedef logic [7:0] cfg_byte_t;
  typedef logic [3:0] pop_code_t;
  typedef logic [9:0] capacity_mb_t;

  // Which kind of answer a configuration read gets
  typedef enum logic [1:0] {
    RD_PASS,
    RD_LOCAL,
    RD_HIDDEN,
    RD_ZEROED
  } read_kind_e;

endpackage

// ---- src/dimm_population_decoder.sv ----
// Decoder from a 4-bit DIMM population code to DIMM geometry
`include "aperture_dram_defs.svh"

module dimm_population_decoder
  import aperture_dram_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Population code
  input wire pop_code_t code,
  // Decoded geometry, registered
  output logic populated,
  output logic double_sided,
  output capacity_mb_t capacity_mb,
  output logic [3:0] row_bits,
  output logic [1:0] bank_bits,
  output logic [3:0] col_bits
);

  logic [20:0] entry_nxt;
  logic [20:0] entry_r;

  // Geometry table {ds, capacity, row, bank, col}; shared codes take the
  // first device mix, column width is that of the front side
  always_comb
  begin
    case (code)
      4'h1: entry_nxt = {1'b1, 10'd32, 4'd11, 2'd1, 4'd9};
      4'h2: entry_nxt = {1'b0, 10'd32, 4'd12, 2'd2, 4'd8};
      4'h3: entry_nxt = {1'b1, 10'd48, 4'd12, 2'd2, 4'd8};
      4'h4: entry_nxt = {1'b1, 10'd64, 4'd12, 2'd2, 4'd8};
      4'h5: entry_nxt = {1'b0, 10'd64, 4'd12, 2'd2, 4'd9};
      4'h6: entry_nxt = {1'b1, 10'd96, 4'd12, 2'd2, 4'd9};
      4'h7: entry_nxt = {1'b1, 10'd128, 4'd12, 2'd2, 4'd9};
      4'h9: entry_nxt = {1'b0, 10'd128, 4'd12, 2'd2, 4'd10};
      4'ha: entry_nxt = {1'b0, 10'd128, 4'd13, 2'd2, 4'd9};
      4'hb: entry_nxt = {1'b1, 10'd192, 4'd12, 2'd2, 4'd10};
      4'hc: entry_nxt = {1'b1, 10'd256, 4'd12, 2'd2, 4'd10};
      4'hd: entry_nxt = {1'b1, 10'd256, 4'd13, 2'd2, 4'd9};
      4'he: entry_nxt = {1'b0, 10'd256, 4'd13, 2'd2, 4'd10};
      4'hf: entry_nxt = {1'b1, 10'd512, 4'd13, 2'd2, 4'd10};
      // Empty slot and the unassigned code both read as no DIMM
      default: entry_nxt = '0;
    endcase
  end

  // Register the looked-up entry
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      entry_r <= '0;
    end
    else
    begin
      entry_r <= entry_nxt;
    end
  end

  assign double_sided = entry_r[20];
  assign capacity_mb = entry_r[19:10];
  assign row_bits = entry_r[9:6];
  assign bank_bits = entry_r[5:4];
  assign col_bits = entry_r[3:0];
  assign populated = entry_r[19:10] != '0;

endmodule

// ---- src/aperture_and_dram_population_regs.sv ----
// Aperture control and DRAM row population registers of the host bridge
//
// Overview of operation
// - Select lock is write-once until reset
// - Lock set makes graphics port select read-only
// - Aperture enable low refuses all aperture accesses
// - Select 0 hides function 2, reads all ones
// - Select 1 hides function 1, reads all ones
// - Select 1 zeroes graphics-port function 0 reads
// - Graphics answers only with smm bits and select
// - Config lock makes row population read-only
// - Row population: DIMM1 high, DIMM0 low nibble
// - Six 64-bit rows on three DIMMs; this block decodes two DIMMs, four rows
// - Decode population codes into DIMM geometry
`include "aperture_dram_defs.svh"

module aperture_and_dram_population_regs
  import aperture_dram_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Configuration cycle port
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [2:0] cfg_func,
  input wire logic [7:0] cfg_offset,
  input wire cfg_byte_t cfg_wdata,
  input wire logic cfg_gport_reg,
  input wire cfg_byte_t cfg_ext_rdata,
  output cfg_byte_t cfg_rdata,
  output logic cfg_rd_valid,
  // Neighbouring register state
  input wire logic memory_config_lock,
  input wire logic [1:0] smm_space_control_hi,
  // Aperture requests: processor, primary PCI, graphics port
  input wire logic [2:0] aperture_req,
  output logic [2:0] aperture_grant,
  // Function visibility
  output logic graphics_port_select,
  output logic gport_func_visible,
  output logic internal_graphics_claim,
  // Decoded DIMM geometry, index 0 is the first DIMM
  output logic [1:0] dimm_populated,
  output logic [1:0] dimm_double_sided,
  output capacity_mb_t dimm_capacity_mb [`DIMMS_HERE],
  output logic [3:0] dimm_row_bits [`DIMMS_HERE],
  output logic [1:0] dimm_bank_bits [`DIMMS_HERE],
  output logic [3:0] dimm_col_bits [`DIMMS_HERE],
  output logic [3:0] row_populated
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  // Assert at once, release after two clean edges
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_sync_r <= 2'b00;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic hits(input logic [2:0] func,
                                input logic [7:0] ofs,
                                input logic [7:0] target);
    hits = (func == `FN_HOST) && (ofs == target);
  endfunction

  logic wr_apc, wr_pop, rd_apc, rd_pop;
  assign wr_apc = cfg_wr && hits(cfg_func, cfg_offset, `OFS_APERTURE_CONTROL);
  assign wr_pop = cfg_wr && hits(cfg_func, cfg_offset,
                                 `OFS_DRAM_ROW_POPULATION);
  assign rd_apc = cfg_rd && hits(cfg_func, cfg_offset, `OFS_APERTURE_CONTROL);
  assign rd_pop = cfg_rd && hits(cfg_func, cfg_offset,
                                 `OFS_DRAM_ROW_POPULATION);

  // ----------------------------------------
  // Aperture control register
  // ----------------------------------------
  logic sel_r, sel_nxt, ena_r, ena_nxt;
  logic lock_r, lock_nxt, lock_written_r, lock_written_nxt;
  // Writes use the lock as it stood before the write, so one write may
  // both choose the select and lock it
  always_comb
  begin
    sel_nxt = sel_r;
    ena_nxt = ena_r;
    lock_nxt = lock_r;
    lock_written_nxt = lock_written_r;
    if (wr_apc)
    begin
      ena_nxt = cfg_wdata[`APC_ENABLE_BIT];
      if (!lock_r)
      begin
        sel_nxt = cfg_wdata[`APC_SELECT_BIT];
      end
      if (!lock_written_r)
      begin
        lock_nxt = cfg_wdata[`APC_LOCK_BIT];
        lock_written_nxt = 1'b1;
      end
    end
  end

  // Only a system reset reopens the write-once lock
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_r <= 1'(`APC_RESET >> `APC_SELECT_BIT);
      ena_r <= 1'(`APC_RESET >> `APC_ENABLE_BIT);
      lock_r <= 1'(`APC_RESET >> `APC_LOCK_BIT);
      lock_written_r <= 1'b0;
    end
    else
    begin
      sel_r <= sel_nxt;
      ena_r <= ena_nxt;
      lock_r <= lock_nxt;
      lock_written_r <= lock_written_nxt;
    end
  end

  // ----------------------------------------
  // Row population register
  // ----------------------------------------
  cfg_byte_t pop_r, pop_nxt;
  // Whole register frozen while the memory configuration is locked
  always_comb
  begin
    pop_nxt = pop_r;
    if (wr_pop && !memory_config_lock)
    begin
      pop_nxt = cfg_wdata;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pop_r <= `POP_RESET;
    end
    else
    begin
      pop_r <= pop_nxt;
    end
  end

  // ----------------------------------------
  // Visibility and aperture gating
  // ----------------------------------------
  assign graphics_port_select = sel_r;
  assign gport_func_visible = !sel_r;
  assign internal_graphics_claim = sel_r && (smm_space_control_hi != 2'b00);
  assign aperture_grant = ena_r ? aperture_req : 3'b000;

  // ----------------------------------------
  // Configuration read path
  // ----------------------------------------
  read_kind_e rd_kind;
  cfg_byte_t local_rdata, rdata_r, rdata_nxt;
  logic rd_valid_r;
  // Reserved high bits of aperture control always read zero
  always_comb
  begin
    local_rdata = '0;
    if (rd_apc)
    begin
      local_rdata[`APC_SELECT_BIT] = sel_r;
      local_rdata[`APC_ENABLE_BIT] = ena_r;
      local_rdata[`APC_LOCK_BIT] = lock_r;
    end
    else if (rd_pop)
    begin
      local_rdata = pop_r;
    end
  end

  // Hidden functions float high, graphics-port registers read as zero when select is 1
  always_comb
  begin
    rd_kind = RD_PASS;
    if (cfg_func == `FN_GFX && !internal_graphics_claim)
    begin
      rd_kind = RD_HIDDEN;
    end
    else if (cfg_func == `FN_GPORT && sel_r)
    begin
      rd_kind = RD_HIDDEN;
    end
    else if (rd_apc || rd_pop)
    begin
      rd_kind = RD_LOCAL;
    end
    else if (cfg_func == `FN_HOST && cfg_gport_reg && sel_r)
    begin
      rd_kind = RD_ZEROED;
    end
  end

  always_comb
  begin
    rdata_nxt = rdata_r;
    if (cfg_rd)
    begin
      case (rd_kind)
        RD_LOCAL: rdata_nxt = local_rdata;
        RD_HIDDEN: rdata_nxt = `READ_HIDDEN;
        RD_ZEROED: rdata_nxt = `READ_ZEROED;
        default: rdata_nxt = cfg_ext_rdata;
      endcase
    end
  end

  // Read data held until the next read so a slow master can sample it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_r <= '0;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rd_valid_r <= cfg_rd;
    end
  end

  assign cfg_rdata = rdata_r;
  assign cfg_rd_valid = rd_valid_r;

  // ----------------------------------------
  // DIMM geometry decode
  // ----------------------------------------
  pop_code_t dimm_code [`DIMMS_HERE];
  assign dimm_code[0] = pop_r[`POP_DIMM0_HI:`POP_DIMM0_LO];
  assign dimm_code[1] = pop_r[`POP_DIMM1_HI:`POP_DIMM1_LO];

  // Each DIMM carries up to two of the six 64-bit rows; the third slot
  // lives in the extension register outside this block
  genvar gi;
  generate
    for (gi = 0; gi < `DIMMS_HERE; gi++)
    begin : g_dimm
      dimm_population_decoder u_dec (
        .clk(ref_clk),
        .rst_n(rst_n),
        .code(dimm_code[gi]),
        .populated(dimm_populated[gi]),
        .double_sided(dimm_double_sided[gi]),
        .capacity_mb(dimm_capacity_mb[gi]),
        .row_bits(dimm_row_bits[gi]),
        .bank_bits(dimm_bank_bits[gi]),
        .col_bits(dimm_col_bits[gi])
      );
      assign row_populated[2 * gi] = dimm_populated[gi];
      assign row_populated[2 * gi + 1] = dimm_double_sided[gi];
    end
  endgenerate

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_lock_write_once: assert property (
    lock_written_r |=> (lock_r == $past(lock_r)) && lock_written_r)
    else $error("select lock changed after its first write");
  a_select_frozen: assert property (
    (wr_apc && lock_r) |=> sel_r == $past(sel_r))
    else $error("graphics port select written while locked");
  a_select_open: assert property (
    (wr_apc && !lock_r) |=> sel_r == $past(cfg_wdata[`APC_SELECT_BIT]))
    else $error("graphics port select write lost while unlocked");
  a_aperture_refused: assert property (
    !ena_r |-> aperture_grant == 3'b000)
    else $error("aperture access granted while disabled");
  a_func2_hidden: assert property (
    (cfg_rd && cfg_func == `FN_GFX && !sel_r)
      |=> cfg_rd_valid && cfg_rdata == `READ_HIDDEN)
    else $error("hidden graphics function did not read all ones");
  a_func1_hidden: assert property (
    (cfg_rd && cfg_func == `FN_GPORT && sel_r)
      |=> cfg_rd_valid && cfg_rdata == `READ_HIDDEN)
    else $error("hidden graphics port function did not read all ones");
  a_gport_zeroed: assert property (
    (cfg_rd && cfg_func == `FN_HOST && cfg_gport_reg && sel_r
      && !rd_apc && !rd_pop) |=> cfg_rdata == `READ_ZEROED)
    else $error("graphics port register not zero in graphics mode");
  a_gfx_claim: assert property (
    (cfg_rd && cfg_func == `FN_GFX && smm_space_control_hi == 2'b00) |=>
      cfg_rdata == `READ_HIDDEN)
    else $error("internal graphics answered without both conditions");
  a_pop_locked: assert property (
    (wr_pop && memory_config_lock) |=> $stable(pop_r))
    else $error("row population changed while locked");
  a_pop_readback: assert property (
    (rd_pop && !wr_pop) |=> cfg_rdata[`POP_DIMM1_HI:`POP_DIMM1_LO]
      == dimm_code[1] && cfg_rdata[`POP_DIMM0_HI:`POP_DIMM0_LO]
      == dimm_code[0])
    else $error("row population fields read back in wrong place");
  a_decode_empty: assert property (
    (dimm_code[0] == `CODE_EMPTY && !wr_pop)
      |=> !dimm_populated[0] && dimm_capacity_mb[0] == '0)
    else $error("empty DIMM decoded as populated");
  a_reserved_zero: assert property (
    rd_apc |=> cfg_rdata[`APC_RESERVED_HI:`APC_RESERVED_LO] == '0)
    else $error("reserved aperture control bits not zero");

  c_lock_then_write: cover property (
    (wr_apc && lock_r) ##1 (rd_apc));
  c_graphics_mode_claim: cover property (
    sel_r && internal_graphics_claim ##1 cfg_rd);
  c_aperture_grant: cover property (
    ena_r && aperture_req != 3'b000);
  c_pop_locked_write: cover property (
    wr_pop && memory_config_lock);

endmodule

// ---- sim/testbench.sv ----
// Self-checking bench for the aperture control and row population registers
`include "aperture_dram_defs.svh"

module testbench
  import aperture_dram_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic ref_clk, nrst, cfg_wr, cfg_rd, cfg_gport_reg, memory_config_lock;
  logic [2:0] cfg_func, aperture_req, aperture_grant;
  logic [7:0] cfg_offset;
  cfg_byte_t cfg_wdata, cfg_ext_rdata, cfg_rdata;
  logic cfg_rd_valid, graphics_port_select, gport_func_visible;
  logic internal_graphics_claim;
  logic [1:0] smm_space_control_hi, dimm_populated, dimm_double_sided;
  capacity_mb_t dimm_capacity_mb [`DIMMS_HERE];
  logic [3:0] dimm_row_bits [`DIMMS_HERE];
  logic [1:0] dimm_bank_bits [`DIMMS_HERE];
  logic [3:0] dimm_col_bits [`DIMMS_HERE];
  logic [3:0] row_populated;
  cfg_byte_t exp_q [$];
  int n_fail, n_checks;

  aperture_and_dram_population_regs dut (
    .ref_clk, .nrst, .cfg_wr, .cfg_rd, .cfg_func, .cfg_offset, .cfg_wdata,
    .cfg_gport_reg, .cfg_ext_rdata, .cfg_rdata, .cfg_rd_valid,
    .memory_config_lock, .smm_space_control_hi, .aperture_req,
    .aperture_grant, .graphics_port_select, .gport_func_visible,
    .internal_graphics_claim, .dimm_populated, .dimm_double_sided,
    .dimm_capacity_mb, .dimm_row_bits, .dimm_bank_bits, .dimm_col_bits,
    .row_populated
  );

  // Free-running 250 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic chk(input logic [21:0] got, input logic [21:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // An answer with no note pending must still count as a mismatch
  task automatic chk_rd(input cfg_byte_t got);
    if (exp_q.size() == 0)
    begin
      n_fail++;
      $display("MISMATCH %0t read answer with no note", $time);
    end
    else
    begin
      chk(22'(got), 22'(exp_q.pop_front()), "read data");
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Read answers are settled by the falling edge during the valid pulse
  always @(negedge ref_clk)
  begin
    if (cfg_rd_valid === 1'b1)
      chk_rd(cfg_rdata);
  end

  // Cuts a hang short
  initial
  begin
    repeat (50000) @(posedge ref_clk);
    n_fail++;
    $display("MISMATCH %0t watchdog expired", $time);
    final_report();
  end

  // ----------------------------------------------------------------
  // Drivers, all on the falling edge
  // ----------------------------------------------------------------
  task automatic do_reset;
    nrst = 1'b0;
    repeat (20) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] ofs, input cfg_byte_t d);
    @(negedge ref_clk);
    cfg_wr = 1'b1;
    cfg_func = `FN_HOST;
    cfg_offset = ofs;
    cfg_wdata = d;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    cfg_wdata = cfg_byte_t'($urandom);
  endtask

  // Expected answer is either the fixed value or the outside data
  task automatic rd(input logic [2:0] fn, input logic [7:0] ofs,
                    input logic gp, input logic ext, input cfg_byte_t e);
    @(negedge ref_clk);
    cfg_rd = 1'b1;
    cfg_func = fn;
    cfg_offset = ofs;
    cfg_gport_reg = gp;
    cfg_ext_rdata = cfg_byte_t'($urandom);
    exp_q.push_back(ext ? cfg_ext_rdata : e);
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    cfg_ext_rdata = ~cfg_ext_rdata;
  endtask

  // Every request mix, grant seen in the same cycle
  task automatic ap_check(input logic en);
    for (int k = 0; k < 8; k++)
    begin
      @(negedge ref_clk);
      aperture_req = 3'(k);
      #1;
      chk(22'(aperture_grant), en ? 22'(k) : 22'h0, "aperture grant");
    end
  endtask

  // {populated, double sided, capacity, row, bank, column}
  function automatic logic [21:0] geom(input pop_code_t c);
    case (c)
      4'h1: return {2'h3, 10'h020, 4'hb, 2'h1, 4'h9};
      4'h2: return {2'h2, 10'h020, 4'hc, 2'h2, 4'h8};
      4'h3: return {2'h3, 10'h030, 4'hc, 2'h2, 4'h8};
      4'h4: return {2'h3, 10'h040, 4'hc, 2'h2, 4'h8};
      4'h5: return {2'h2, 10'h040, 4'hc, 2'h2, 4'h9};
      4'h6: return {2'h3, 10'h060, 4'hc, 2'h2, 4'h9};
      4'h7: return {2'h3, 10'h080, 4'hc, 2'h2, 4'h9};
      4'h9: return {2'h2, 10'h080, 4'hc, 2'h2, 4'ha};
      4'ha: return {2'h2, 10'h080, 4'hd, 2'h2, 4'h9};
      4'hb: return {2'h3, 10'h0c0, 4'hc, 2'h2, 4'ha};
      4'hc: return {2'h3, 10'h100, 4'hc, 2'h2, 4'ha};
      4'hd: return {2'h3, 10'h100, 4'hd, 2'h2, 4'h9};
      4'he: return {2'h2, 10'h100, 4'hd, 2'h2, 4'ha};
      4'hf: return {2'h3, 10'h200, 4'hd, 2'h2, 4'ha};
      default: return 22'h0;
    endcase
  endfunction

  task automatic chk_dimm(input int i, input pop_code_t c);
    chk({dimm_populated[i], dimm_double_sided[i], dimm_capacity_mb[i],
         dimm_row_bits[i], dimm_bank_bits[i], dimm_col_bits[i]},
        geom(c), "dimm geometry");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [21:0] g0, g1;
    pop_code_t c0, c1;
    nrst = 1'b0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_func = 3'h0;
    cfg_offset = 8'h00;
    cfg_wdata = 8'h00;
    cfg_gport_reg = 1'b0;
    cfg_ext_rdata = 8'h00;
    memory_config_lock = 1'b0;
    smm_space_control_hi = 2'h0;
    aperture_req = 3'h0;
    n_fail = 0;
    n_checks = 0;
    void'($urandom(20));
    do_reset();
    // Select is programmed before any other access
    wr(`OFS_APERTURE_CONTROL, 8'h00);
    rd(`FN_HOST, `OFS_APERTURE_CONTROL, 1'b0, 1'b0, `APC_RESET);
    rd(`FN_HOST, `OFS_DRAM_ROW_POPULATION, 1'b0, 1'b0, `POP_RESET);
    ap_check(1'b0);
    rd(`FN_GFX, 8'h00, 1'b0, 1'b0, `READ_HIDDEN);
    rd(`FN_GPORT, 8'h10, 1'b0, 1'b1, 8'h00);
    rd(`FN_HOST, 8'hb0, 1'b1, 1'b1, 8'h00);
    chk(22'(gport_func_visible), 22'h1, "function 1 visible");
    // Second write sets enable with lock clear; reserved bits must vanish
    wr(`OFS_APERTURE_CONTROL, 8'hfa);
    rd(`FN_HOST, `OFS_APERTURE_CONTROL, 1'b0, 1'b0, 8'h02);
    ap_check(1'b1);
    // Lock was consumed at 0, so select stays writable
    wr(`OFS_APERTURE_CONTROL, 8'h05);
    rd(`FN_HOST, `OFS_APERTURE_CONTROL, 1'b0, 1'b0, 8'h01);
    ap_check(1'b0);
    chk(22'(graphics_port_select), 22'h1, "select");
    chk(22'(gport_func_visible), 22'h0, "function 1 visible");
    rd(`FN_GPORT, 8'h10, 1'b0, 1'b0, `READ_HIDDEN);
    rd(`FN_HOST, 8'hb0, 1'b1, 1'b0, `READ_ZEROED);
    rd(`FN_HOST, 8'h34, 1'b0, 1'b1, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      @(negedge ref_clk);
      smm_space_control_hi = 2'(s);
      #1;
      chk(22'(internal_graphics_claim), 22'(s != 0), "claim");
      rd(`FN_GFX, 8'h00, 1'b0, s != 0, `READ_HIDDEN);
    end
    // Second reset, then lock and select in one write
    do_reset();
    wr(`OFS_APERTURE_CONTROL, 8'h05);
    rd(`FN_HOST, `OFS_APERTURE_CONTROL, 1'b0, 1'b0, 8'h05);
    wr(`OFS_APERTURE_CONTROL, 8'h02);
    rd(`FN_HOST, `OFS_APERTURE_CONTROL, 1'b0, 1'b0, 8'h07);
    // Every population code on both DIMMs, codes paired off-step
    // Two DIMMs never pass the fast memory clock population limit
    for (int i = 0; i < 16; i++)
    begin
      c0 = pop_code_t'(i);
      c1 = pop_code_t'(i + 4);
      wr(`OFS_DRAM_ROW_POPULATION, {c1, c0});
      rd(`FN_HOST, `OFS_DRAM_ROW_POPULATION, 1'b0, 1'b0, {c1, c0});
      @(negedge ref_clk);
      g0 = geom(c0);
      g1 = geom(c1);
      chk_dimm(0, c0);
      chk_dimm(1, c1);
      chk(22'(row_populated), 22'({g1[20] & g1[21], g1[21], g0[20] & g0[21],
          g0[21]}), "row populated");
    end
    // Frozen population ignores a write
    memory_config_lock = 1'b1;
    wr(`OFS_DRAM_ROW_POPULATION, 8'h3c);
    rd(`FN_HOST, `OFS_DRAM_ROW_POPULATION, 1'b0, 1'b0, {c1, c0});
    memory_config_lock = 1'b0;
    for (int w = 0; w < 10 && exp_q.size() != 0; w++)
      @(negedge ref_clk);
    if (exp_q.size() != 0)
    begin
      n_fail++;
      $display("MISMATCH %0t read answers missing", $time);
    end
    final_report();
  end
endmodule
